// ---- cgyc_map.vh ----
// register offsets, field positions and reset values of the colour config bank
`ifndef CGYC_MAP_VH
`define CGYC_MAP_VH
`define CGYC_OFS_OFFSET_BLUE 8'h00
`define CGYC_OFS_GAMMA_CFG 8'h04
`define CGYC_OFS_LUMA_ADJ 8'h08
`define CGYC_OFS_MUL_RY 8'h0C
`define CGYC_OFS_MUL_GY 8'h10
`define CGYC_OFS_MUL_BY 8'h14
`define CGYC_OFS_MUL_RCB 8'h18
`define CGYC_OFS_MUL_GCB 8'h1C
`define CGYC_OFS_MUL_BCB 8'h20
`define CGYC_OFS_STATUS 8'h24
`define CGYC_GMM_SIZE_HI 6
`define CGYC_GMM_SIZE_LO 5
`define CGYC_GMM_SRC_BIT 4
`define CGYC_GMM_SKIP_B_BIT 2
`define CGYC_GMM_SKIP_G_BIT 1
`define CGYC_GMM_SKIP_R_BIT 0
`define CGYC_RST_OFFSET_BLUE 13'h0000
`define CGYC_RST_GMM_SIZE 2'h3
`define CGYC_RST_GMM_SRC 1'h0
`define CGYC_RST_GMM_SKIP 3'h7
`define CGYC_RST_BRIGHT 8'h00
`define CGYC_RST_CONTRAST 8'h10
`define CGYC_RST_MUL_RY 12'h04D
`define CGYC_RST_MUL_GY 12'h096
`define CGYC_RST_MUL_BY 12'h01D
`define CGYC_RST_MUL_RCB 12'hFD5
`define CGYC_RST_MUL_GCB 12'hFAB
`define CGYC_RST_MUL_BCB 12'h080
`define CGYC_GMM_WORDS_BASE 10'h040
`endif

// ---- cgyc_matrix_row.v ----
// one row of a 3x3 colour matrix with S3.8 coefficients and a registered output
`timescale 1ns/10ps
`default_nettype none
module cgyc_matrix_row #(
  parameter PIX_W = 10
) (
  input wire clk_i, // pipe clock
  input wire rst_i, // sync reset
  input wire [PIX_W-1:0] red_i, // red input
  input wire [PIX_W-1:0] green_i, // green input
  input wire [PIX_W-1:0] blue_i, // blue input
  input wire [11:0] coef_r_i, // red weight
  input wire [11:0] coef_g_i, // green weight
  input wire [11:0] coef_b_i, // blue weight
  output reg [PIX_W+4:0] sum_o // signed weighted sum
);
  wire signed [PIX_W+13:0] prod_r;
  wire signed [PIX_W+13:0] prod_g;
  wire signed [PIX_W+13:0] prod_b;
  wire signed [PIX_W+13:0] total;
  assign prod_r = $signed({1'b0, red_i}) * $signed(coef_r_i);
  assign prod_g = $signed({1'b0, green_i}) * $signed(coef_g_i);
  assign prod_b = $signed({1'b0, blue_i}) * $signed(coef_b_i);
  // round half up, then drop the eight fraction bits
  assign total = prod_r + prod_g + prod_b + $signed({{(PIX_W+6){1'b0}}, 8'h80});
  // saturate when the rounded sum leaves the output range
  always @(posedge clk_i)
  begin
    if (rst_i)
      sum_o <= {(PIX_W+5){1'b0}};
    else if (total[PIX_W+13] != total[PIX_W+12])
      sum_o <= {total[PIX_W+13], {(PIX_W+4){~total[PIX_W+13]}}};
    else
      sum_o <= total[PIX_W+12:8];
  end
endmodule // cgyc_matrix_row
`default_nettype wire

// ---- cgyc_config.v ----
// colour path configuration bank: wishbone registers plus the datapath using them
`timescale 1ns/10ps
`default_nettype none
`include "cgyc_map.vh"
module cgyc_config #(
  parameter PIX_W = 10
) (
  input wire clk_i, // pipe clock
  input wire rst_i, // sync reset, active high
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  input wire wb_we_i, // write enable
  input wire [7:0] wb_adr_i, // byte address
  input wire [3:0] wb_sel_i, // byte lanes
  input wire [31:0] wb_dat_i, // write data
  output reg [31:0] wb_dat_o, // read data
  output wire wb_ack_o, // acknowledge
  output wire wb_err_o, // unmapped address
  input wire pix_valid_i, // pixel strobe
  input wire [PIX_W-1:0] blue_cc_i, // blue from colour matrix, before offset
  input wire [PIX_W-1:0] red_i, // red into yc matrix
  input wire [PIX_W-1:0] green_i, // green into yc matrix
  input wire [PIX_W-1:0] blue_i, // blue into yc matrix
  output reg [PIX_W-1:0] blue_cc_o, // blue after offset, clipped
  output wire [9:0] gamma_words_o, // gamma table entries
  output wire gamma_source_select_o, // one selects ROM table
  output wire gamma_skip_blue_o, // blue uncorrected
  output wire gamma_skip_green_o, // green uncorrected
  output wire gamma_skip_red_o, // red uncorrected
  output reg [PIX_W-1:0] luma_o, // adjusted luma
  output reg [PIX_W-1:0] blue_diff_o, // blue-difference chroma, signed
  output reg pix_valid_o // output strobe
);
  reg [12:0] rgb_offset_blue_q;
  reg [1:0] gamma_table_size_q;
  reg gamma_source_select_q;
  reg [2:0] gamma_skip_q;
  reg [7:0] brightness_offset_q;
  reg [7:0] contrast_gain_q;
  reg [11:0] matrix_red_to_luma_q;
  reg [11:0] matrix_green_to_luma_q;
  reg [11:0] matrix_blue_to_luma_q;
  reg [11:0] matrix_red_to_blue_diff_q;
  reg [11:0] matrix_green_to_blue_diff_q;
  reg [11:0] matrix_blue_to_blue_diff_q;
  reg ack_q;
  reg err_q;
  reg valid_pipe_q;
  reg [31:0] rd_d;
  reg hit_d;
  wire req;
  wire wr;
  wire [31:0] wmask;
  wire [31:0] wval;

  wire wr_offset_blue;
  wire wr_gamma_cfg;
  wire wr_luma_adj;
  wire wr_mul_ry;
  wire wr_mul_gy;
  wire wr_mul_by;
  wire wr_mul_rcb;
  wire wr_mul_gcb;
  wire wr_mul_bcb;
  wire [PIX_W+4:0] luma_raw;
  wire [PIX_W+4:0] bdiff_raw;
  reg [PIX_W+13:0] luma_scaled_d;
  reg [PIX_W+13:0] luma_bright_d;
  reg signed [PIX_W+4:0] bdiff_d;
  reg signed [PIX_W+3:0] bsum_d;
  // offset sign-extended to the sum width
  wire signed [PIX_W+3:0] offset_ext;
  reg [PIX_W-1:0] blue_cc_d;
  reg [PIX_W-1:0] luma_d;
  reg [PIX_W-1:0] blue_diff_d;
  localparam [PIX_W-1:0] PIX_MAX = {PIX_W{1'b1}};
  localparam [PIX_W-1:0] CHROMA_MAX = {1'b0, {(PIX_W-1){1'b1}}};
  localparam [PIX_W-1:0] CHROMA_MIN = {1'b1, {(PIX_W-1){1'b0}}};

  // one wait-free answer per request, dropped the cycle after
  assign req = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
  assign wr = req & wb_we_i & hit_d;
  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_lane
      assign wmask[gi*8+7:gi*8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  // merge written lanes with current contents
  assign wval = (wb_dat_i & wmask) | (rd_d & ~wmask);

  always @*
  begin
    rd_d = 32'h00000000;
    hit_d = 1'b1;
    case (wb_adr_i)
      `CGYC_OFS_OFFSET_BLUE: rd_d = {19'h00000, rgb_offset_blue_q};
      `CGYC_OFS_GAMMA_CFG: rd_d = {25'h0000000, gamma_table_size_q, gamma_source_select_q, 1'b0, gamma_skip_q};
      `CGYC_OFS_LUMA_ADJ: rd_d = {16'h0000, brightness_offset_q, contrast_gain_q};
      `CGYC_OFS_MUL_RY: rd_d = {20'h00000, matrix_red_to_luma_q};
      `CGYC_OFS_MUL_GY: rd_d = {20'h00000, matrix_green_to_luma_q};
      `CGYC_OFS_MUL_BY: rd_d = {20'h00000, matrix_blue_to_luma_q};
      `CGYC_OFS_MUL_RCB: rd_d = {20'h00000, matrix_red_to_blue_diff_q};
      `CGYC_OFS_MUL_GCB: rd_d = {20'h00000, matrix_green_to_blue_diff_q};
      `CGYC_OFS_MUL_BCB: rd_d = {20'h00000, matrix_blue_to_blue_diff_q};
      `CGYC_OFS_STATUS: rd_d = {22'h000000, gamma_words_o};
      default: hit_d = 1'b0;
    endcase
  end

  // registered answer; read data only in the ack cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      ack_q <= req & hit_d;
      err_q <= req & ~hit_d;
      if (req & ~wb_we_i & hit_d)
        wb_dat_o <= rd_d;
      else
        wb_dat_o <= 32'h00000000;
    end
  end

  // reserved bits are discarded; software keeps them zero
  // status writes are acked and dropped
  assign wr_offset_blue = wr & (wb_adr_i == `CGYC_OFS_OFFSET_BLUE);
  assign wr_gamma_cfg = wr & (wb_adr_i == `CGYC_OFS_GAMMA_CFG);
  assign wr_luma_adj = wr & (wb_adr_i == `CGYC_OFS_LUMA_ADJ);
  assign wr_mul_ry = wr & (wb_adr_i == `CGYC_OFS_MUL_RY);
  assign wr_mul_gy = wr & (wb_adr_i == `CGYC_OFS_MUL_GY);
  assign wr_mul_by = wr & (wb_adr_i == `CGYC_OFS_MUL_BY);
  assign wr_mul_rcb = wr & (wb_adr_i == `CGYC_OFS_MUL_RCB);
  assign wr_mul_gcb = wr & (wb_adr_i == `CGYC_OFS_MUL_GCB);
  assign wr_mul_bcb = wr & (wb_adr_i == `CGYC_OFS_MUL_BCB);

  always @(posedge clk_i)
  begin
    if (rst_i)
      rgb_offset_blue_q <= `CGYC_RST_OFFSET_BLUE;
    else if (wr_offset_blue)
      rgb_offset_blue_q <= wval[12:0];
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gamma_table_size_q <= `CGYC_RST_GMM_SIZE;
      gamma_source_select_q <= `CGYC_RST_GMM_SRC;
      gamma_skip_q <= `CGYC_RST_GMM_SKIP;
    end
    else if (wr_gamma_cfg)
    begin
      gamma_table_size_q <= wval[`CGYC_GMM_SIZE_HI:`CGYC_GMM_SIZE_LO];
      gamma_source_select_q <= wval[`CGYC_GMM_SRC_BIT];
      gamma_skip_q <= {wval[`CGYC_GMM_SKIP_B_BIT], wval[`CGYC_GMM_SKIP_G_BIT],
                       wval[`CGYC_GMM_SKIP_R_BIT]};
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      brightness_offset_q <= `CGYC_RST_BRIGHT;
      contrast_gain_q <= `CGYC_RST_CONTRAST;
    end
    else if (wr_luma_adj)
    begin
      brightness_offset_q <= wval[15:8];
      contrast_gain_q <= wval[7:0];
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      matrix_red_to_luma_q <= `CGYC_RST_MUL_RY;
    else if (wr_mul_ry)
      matrix_red_to_luma_q <= wval[11:0];
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      matrix_green_to_luma_q <= `CGYC_RST_MUL_GY;
    else if (wr_mul_gy)
      matrix_green_to_luma_q <= wval[11:0];
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      matrix_blue_to_luma_q <= `CGYC_RST_MUL_BY;
    else if (wr_mul_by)
      matrix_blue_to_luma_q <= wval[11:0];
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      matrix_red_to_blue_diff_q <= `CGYC_RST_MUL_RCB;
    else if (wr_mul_rcb)
      matrix_red_to_blue_diff_q <= wval[11:0];
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      matrix_green_to_blue_diff_q <= `CGYC_RST_MUL_GCB;
    else if (wr_mul_gcb)
      matrix_green_to_blue_diff_q <= wval[11:0];
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      matrix_blue_to_blue_diff_q <= `CGYC_RST_MUL_BCB;
    else if (wr_mul_bcb)
      matrix_blue_to_blue_diff_q <= wval[11:0];
  end

  // 64 shifted by the size code
  assign gamma_words_o = `CGYC_GMM_WORDS_BASE << gamma_table_size_q;
  assign gamma_source_select_o = gamma_source_select_q;
  assign gamma_skip_blue_o = gamma_skip_q[2];
  assign gamma_skip_green_o = gamma_skip_q[1];
  assign gamma_skip_red_o = gamma_skip_q[0];

  // blue offset, saturated to the pixel range
  assign offset_ext = {{(PIX_W-9){rgb_offset_blue_q[12]}}, rgb_offset_blue_q};

  always @*
  begin
    bsum_d = $signed({4'h0, blue_cc_i}) + offset_ext;
    if (bsum_d < 0)
      blue_cc_d = {PIX_W{1'b0}};
    else if (bsum_d > $signed({4'h0, PIX_MAX}))
      blue_cc_d = PIX_MAX;
    else
      blue_cc_d = bsum_d[PIX_W-1:0];
  end

  // held between pixel strobes
  always @(posedge clk_i)
  begin
    if (rst_i)
      blue_cc_o <= {PIX_W{1'b0}};
    else if (pix_valid_i)
      blue_cc_o <= blue_cc_d;
  end

  cgyc_matrix_row #(
    .PIX_W(PIX_W)
  ) u_luma_row (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .red_i(red_i),
    .green_i(green_i),
    .blue_i(blue_i),
    .coef_r_i(matrix_red_to_luma_q),
    .coef_g_i(matrix_green_to_luma_q),
    .coef_b_i(matrix_blue_to_luma_q),
    .sum_o(luma_raw)
  );

  cgyc_matrix_row #(
    .PIX_W(PIX_W)
  ) u_bdiff_row (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .red_i(red_i),
    .green_i(green_i),
    .blue_i(blue_i),
    .coef_r_i(matrix_red_to_blue_diff_q),
    .coef_g_i(matrix_green_to_blue_diff_q),
    .coef_b_i(matrix_blue_to_blue_diff_q),
    .sum_o(bdiff_raw)
  );

  // negative luma clips to zero before contrast
  // contrast then brightness, clipped to the pixel range
  always @*
  begin
    if (luma_raw[PIX_W+4])
      luma_scaled_d = {(PIX_W+14){1'b0}};
    else
      luma_scaled_d = (luma_raw * {{(PIX_W+6){1'b0}}, contrast_gain_q}) >> 4;
    luma_bright_d = luma_scaled_d + {{(PIX_W+6){1'b0}}, brightness_offset_q};
    bdiff_d = $signed(bdiff_raw);
    if (luma_bright_d > {{14{1'b0}}, PIX_MAX})
      luma_d = PIX_MAX;
    else
      luma_d = luma_bright_d[PIX_W-1:0];
    if (bdiff_d > $signed({5'h00, CHROMA_MAX}))
      blue_diff_d = CHROMA_MAX;
    else if (bdiff_d < $signed({5'h1F, CHROMA_MIN}))
      blue_diff_d = CHROMA_MIN;
    else
      blue_diff_d = bdiff_d[PIX_W-1:0];
  end

  // outputs land two cycles after their pixel, with the strobe
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      luma_o <= {PIX_W{1'b0}};
      blue_diff_o <= {PIX_W{1'b0}};
      valid_pipe_q <= 1'b0;
      pix_valid_o <= 1'b0;
    end
    else
    begin
      valid_pipe_q <= pix_valid_i;
      pix_valid_o <= valid_pipe_q;
      luma_o <= luma_d;
      blue_diff_o <= blue_diff_d;
    end
  end
endmodule // cgyc_config
`default_nettype wire

// ---- cgyc_config_chk.sv ----
// port assertions for the colour config bank
`timescale 1ns/10ps
`default_nettype none
module cgyc_config_chk #(
  parameter PIX_W = 10
) (
  input wire clk_i, // clock
  input wire rst_i, // reset
  input wire wb_cyc_i, // cycle
  input wire wb_stb_i, // strobe
  input wire wb_we_i, // write
  input wire [7:0] wb_adr_i, // address
  input wire [3:0] wb_sel_i, // lanes
  input wire [31:0] wb_dat_i, // write data
  input wire [31:0] wb_dat_o, // read data
  input wire wb_ack_o, // ack
  input wire wb_err_o, // refusal
  input wire pix_valid_i, // pixel in
  input wire pix_valid_o, // pixel out
  input wire [PIX_W-1:0] blue_cc_o, // offset blue
  input wire [9:0] gamma_words_o, // table size
  input wire gamma_source_select_o, // rom
  input wire gamma_skip_blue_o, // skip b
  input wire gamma_skip_green_o, // skip g
  input wire gamma_skip_red_o // skip r
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire cfg_wr = req && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0];
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  one_answer_a: assert property (req |=> wb_ack_o != wb_err_o) else $error("no answer");
  unmap_err_a: assert property (req && wb_adr_i > 8'h24 |=> wb_err_o) else $error("no refusal");
  rd_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stray read data");
  size_dec_a: assert property (cfg_wr |=> gamma_words_o == 10'h040 << $past(wb_dat_i[6:5]))
    else $error("table size");
  src_sel_a: assert property (cfg_wr |=> gamma_source_select_o == $past(wb_dat_i[4]))
    else $error("table source");
  skip_bits_a: assert property (cfg_wr |=> {gamma_skip_blue_o, gamma_skip_green_o, gamma_skip_red_o}
    == $past(wb_dat_i[2:0])) else $error("skip bits");
  pv_delay_a: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> pix_valid_o == $past(pix_valid_i, 2))
    else $error("valid delay");
  bcc_hold_a: assert property (!pix_valid_i |=> $stable(blue_cc_o)) else $error("blue moved");
endmodule // cgyc_config_chk
bind cgyc_config cgyc_config_chk #(.PIX_W(PIX_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pix_valid_i(pix_valid_i),
  .pix_valid_o(pix_valid_o), .blue_cc_o(blue_cc_o), .gamma_words_o(gamma_words_o),
  .gamma_source_select_o(gamma_source_select_o), .gamma_skip_blue_o(gamma_skip_blue_o),
  .gamma_skip_green_o(gamma_skip_green_o), .gamma_skip_red_o(gamma_skip_red_o));
`default_nettype wire

// ---- cgyc_host_model.sv ----
// wishbone host that configures the colour bank
`timescale 1ns/10ps
`default_nettype none
module cgyc_host_model (
  input wire clk_i, // clock
  input wire ack_i, // ack
  input wire err_i, // refusal
  input wire [31:0] dat_i, // read data
  output logic cyc_o, // cycle
  output logic stb_o, // strobe
  output logic we_o, // write
  output logic [7:0] adr_o, // address
  output logic [3:0] sel_o, // lanes
  output logic [31:0] dat_o // write data
);
  initial
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  // writable bits of each register
  function automatic [31:0] field_mask(input [7:0] a);
    field_mask = a == 8'h00 ? 32'h1FFF : a == 8'h04 ? 32'h77 : a == 8'h08 ? 32'hFFFF : a <= 8'h20 ? 32'hFFF : 32'h0;
  endfunction
  task automatic xfer(input [7:0] a, input w, input [31:0] d, input [3:0] s, output [31:0] rd, output er);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d & field_mask(a);
    @(posedge clk_i);
    while (!(ack_i || err_i))
      @(posedge clk_i);
    rd = dat_i;
    er = err_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask
endmodule // cgyc_host_model
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the colour config bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, err, e, pv_o, src, skb, skg, skr;
  logic pv_i = 1'b0;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr, q;
  logic [9:0] bcc_i = 10'h000, r_i = 10'h000, g_i = 10'h000, b_i = 10'h000, bcc_o, words, luma, bd;
  integer n_errors = 0, comparisons = 0, seed = 31, i, k, t, y, pr, pg, pb, pc, ln;
  integer m [0:9];
  always #5 clk_i = ~clk_i;
  cgyc_host_model u_cgyc_host_model (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(dr), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dw));
  cgyc_config u_cgyc_config (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .wb_err_o(err),
    .pix_valid_i(pv_i), .blue_cc_i(bcc_i), .red_i(r_i), .green_i(g_i), .blue_i(b_i), .blue_cc_o(bcc_o),
    .gamma_words_o(words), .gamma_source_select_o(src), .gamma_skip_blue_o(skb), .gamma_skip_green_o(skg),
    .gamma_skip_red_o(skr), .luma_o(luma), .blue_diff_o(bd), .pix_valid_o(pv_o));
  function automatic integer sx(input integer v, input integer w);
    sx = v - (((v >> (w - 1)) & 1) << w);
  endfunction
  function automatic integer clip(input integer v, input integer lo, input integer hi);
    clip = v < lo ? lo : (v > hi ? hi : v);
  endfunction
  task chk_reg(input [31:0] got, input [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("FAIL %0t register %h expected %h", $time, got, exp);
    end
  endtask
  task chk_pix(input [9:0] got, input [9:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("FAIL %0t pixel %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check_all;
    for (i = 0; i < 10; i = i + 1)
    begin
      u_cgyc_host_model.xfer(8'(i * 4), 1'b0, 32'h0, 4'hF, q, e);
      chk_reg(q, m[i]);
      chk_reg(e, 0);
    end
    chk_reg(words, 64 << ((m[1] >> 5) & 3));
    chk_reg({src, skb, skg, skr}, ((m[1] >> 1) & 8) | (m[1] & 7));
  endtask
  task pix_run;
    pr = $random(seed) & 1023;
    pg = $random(seed) & 1023;
    pb = $random(seed) & 1023;
    pc = $random(seed) & 1023;
    @(posedge clk_i);
    {r_i, g_i, b_i, bcc_i, pv_i} <= {pr[9:0], pg[9:0], pb[9:0], pc[9:0], 1'b1};
    repeat (3) @(posedge clk_i);
    #1;
    y = (pr * sx(m[3], 12) + pg * sx(m[4], 12) + pb * sx(m[5], 12) + 128) >>> 8;
    chk_pix(luma, clip((((y < 0 ? 0 : y) * (m[2] & 255)) >> 4) + (m[2] >> 8), 0, 1023));
    y = (pr * sx(m[6], 12) + pg * sx(m[7], 12) + pb * sx(m[8], 12) + 128) >>> 8;
    chk_pix(bd, clip(y, -512, 511));
    chk_pix(bcc_o, clip(pc + sx(m[0], 13), 0, 1023));
    chk_pix(pv_o, 1);
    @(posedge clk_i);
    pv_i <= 1'b0;
    bcc_i <= ~bcc_i;
  endtask
  initial
  begin
    #100000;
    n_errors = n_errors + 1;
    test_done;
  end
  initial
  begin
    m = '{0, 32'h67, 32'h10, 77, 150, 29, 32'hFD5, 32'hFAB, 128, 512};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    check_all;
    pix_run;
    u_cgyc_host_model.xfer(8'h28, 1'b0, 32'h0, 4'hF, q, e);
    chk_reg({e, q[30:0]}, 32'h8000_0000);
    u_cgyc_host_model.xfer(8'h24, 1'b1, 32'h0, 4'hF, q, e);
    chk_reg(e, 0);
    for (k = 0; k < 16; k = k + 1)
    begin
      for (i = 0; i < 9; i = i + 1)
      begin
        t = $random(seed);
        t = i == 1 ? ((t & 32'hFFFF_FF9F) | ((k % 4) << 5)) : (i > 2 ? t % 1024 : t);
        ln = i == 1 ? 15 : $random(seed) & 15;
        u_cgyc_host_model.xfer(8'(i * 4), 1'b1, t, ln[3:0], q, e);
        ln = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
        m[i] = ((m[i] & ~ln) | (t & ln)) & u_cgyc_host_model.field_mask(8'(i * 4));
      end
      m[9] = 64 << ((m[1] >> 5) & 3);
      check_all;
      pix_run;
    end
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    m = '{0, 32'h67, 32'h10, 77, 150, 29, 32'hFD5, 32'hFAB, 128, 512};
    check_all;
    pix_run;
    test_done;
  end
endmodule // testbench
`default_nettype wire
